//--- design/ptm_pkg.sv
package ptm_pkg;
    // ****************************************
    // register map (byte addresses, one word each)
    // ****************************************
    localparam logic [5:0] ADDR_CTRL0 = 6'h00; // timer_control_0
    localparam logic [5:0] ADDR_CTRL1 = 6'h04; // timer_control_1
    localparam logic [5:0] ADDR_CNTL = 6'h08; // count_low_byte
    localparam logic [5:0] ADDR_CNTH = 6'h0c; // count_high_byte
    localparam logic [5:0] ADDR_CMPAL = 6'h10; // compare_a_low_byte
    localparam logic [5:0] ADDR_CMPAH = 6'h14; // compare_a_high_byte
    localparam logic [5:0] ADDR_CMPPL = 6'h18; // compare_p_low_byte
    localparam logic [5:0] ADDR_CMPPH = 6'h1c; // compare_p_high_byte
    localparam logic [5:0] ADDR_FLAGS = 6'h20; // match flags, write one to clear
    localparam logic [5:0] ADDR_TOP = 6'h24; // first unmapped byte address

    // ****************************************
    // field positions
    // ****************************************
    localparam int C0_PAU = 7; // pause_ctrl
    localparam int C0_CKH = 6; // clock_select msb
    localparam int C0_CKL = 4; // clock_select lsb
    localparam int C0_ON = 3; // counter_on
    localparam int C1_MH = 7; // operating_mode_sel
    localparam int C1_ML = 6;
    localparam int C1_IOH = 5; // pin_function_sel
    localparam int C1_IOL = 4;
    localparam int C1_OC = 3; // output_level_ctrl
    localparam int C1_POL = 2; // output_invert
    localparam int C1_CAPTS = 1; // capture_source_sel
    localparam int C1_CCLR = 0; // clear_condition_sel
    localparam logic [7:0] C0_WMASK = 8'hf8; // low three bits unimplemented
    localparam int FLAG_A = 0;
    localparam int FLAG_P = 1;

    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [5:0] DIV4_LAST = 6'h03; // prescale wrap for sys/4
    localparam logic [5:0] DIV16_LAST = 6'h0f; // sys/16
    localparam logic [5:0] DIV64_LAST = 6'h3f; // sys/64
    localparam logic [5:0] SUB_LAST = 6'h3f; // slow clock stand-in
    localparam int SUB_DIV_W = 10; // extra stages for the slow clock
    localparam logic [9:0] SUB_LAST_HI = 10'h3ff;

    typedef enum logic [1:0] {
        PTM_MODE_CMP,
        PTM_MODE_CAP,
        PTM_MODE_PWM,
        PTM_MODE_TMR
    } ptm_mode_e;

    typedef enum logic [2:0] {
        PTM_CK_SYS4,
        PTM_CK_SYS,
        PTM_CK_H16,
        PTM_CK_H64,
        PTM_CK_SUB0,
        PTM_CK_SUB1,
        PTM_CK_EXT_RISE,
        PTM_CK_EXT_FALL
    } ptm_clk_e;

    // ****************************************
    // module state
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [15:0] cmp_a;
        logic [15:0] cmp_p;
        logic [15:0] count;
        logic [1:0] flags;
        logic [5:0] presc;
        logic [9:0] sub_presc;
        logic pin_lvl;
        logic [1:0] sync_ck;
        logic ck_prev;
        logic [1:0] sync_cap;
        logic cap_prev;
        logic aw_got;
        logic [5:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic timer_out;
    } ptm_state_s;
endpackage

//--- design/ptm_periodic_timer.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// - pause holds count, resume from held value
// - clock_select picks counter tick source
// - counter_on rise clears counter, starts count
// - counter_on fall stops counter, keeps value
// - counter_on rise restores initial output level
// - operating_mode_sel picks one of four modes
// - timer mode output unused, bits ignored
// - compare match pin action on A match
// - pwm mode pin function selection
// - capture edge selection, or disabled
// - capture source: capture pin or clock pin
// - requested equal initial means no change
// - output_level_ctrl initial level or active level
// - output_invert inverts pin signal
// - clear on A match, or P/overflow
// - overflow clear only when P is zero
// - clear select ignored outside compare/timer modes
// - counter readable as low/high bytes
// - compare A and P byte pairs, reset zero
// - two 16-bit comparators against counter
// - A match sets flag A unless A is zero outside capture; P match sets flag P unless clearing on A
module ptm_periodic_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clock_pin,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic [1:0] match_flags
);
    // ****************************************
    // state and decoded fields
    // ****************************************
    ptm_pkg::ptm_state_s state_ff; // whole registered state
    ptm_pkg::ptm_state_s nxt_state; // its next value
    ptm_pkg::ptm_mode_e mode; // decoded operating mode
    ptm_pkg::ptm_clk_e ck_sel; // decoded clock source
    logic [1:0] pin_fn; // pin_function_sel
    logic on_bit; // counter_on
    logic on_rise; // rising edge of counter_on, from software or the single pulse clock pin trigger
    logic ext_rise; // synchronised clock pin rise
    logic ext_fall; // synchronised clock pin fall
    logic cap_rise; // capture source rise
    logic cap_fall; // capture source fall
    logic cap_hit; // capture trigger
    logic tick; // selected tick source pulse, counter advances only with cnt_en
    logic match_a; // comparator a equal
    logic match_p; // comparator p equal
    logic cnt_en; // counter allowed to run
    logic wr_fire; // write both halves held
    logic [7:0] wbyte; // written low byte
    logic wr_ok; // write address below ADDR_TOP
    logic [7:0] new_ctrl0; // control 0 after this write
    logic [5:0] presc_last; // prescale wrap value
    logic cleared; // counter cleared this tick
    logic pwm_act; // pwm active phase
    logic lvl_cmp; // output level before polarity, every mode
    logic [1:0] flag_set; // match flags raised this cycle

    assign mode = ptm_pkg::ptm_mode_e'(state_ff.ctrl1[ptm_pkg::C1_MH:ptm_pkg::C1_ML]);
    assign ck_sel = ptm_pkg::ptm_clk_e'(state_ff.ctrl0[ptm_pkg::C0_CKH:ptm_pkg::C0_CKL]);
    assign pin_fn = state_ff.ctrl1[ptm_pkg::C1_IOH:ptm_pkg::C1_IOL];
    assign on_bit = state_ff.ctrl0[ptm_pkg::C0_ON];
    assign wr_fire = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
    assign wbyte = state_ff.w_data[7:0];
    assign wr_ok = state_ff.aw_addr < ptm_pkg::ADDR_TOP;

    // ****************************************
    // pin edge detection on synchronised copies
    // ****************************************
    // edges come from the second stage only
    assign ext_rise = state_ff.sync_ck[1] && !state_ff.ck_prev;
    assign ext_fall = !state_ff.sync_ck[1] && state_ff.ck_prev;
    // capture source is the capture pin or the clock pin
    always_comb begin
        if (state_ff.ctrl1[ptm_pkg::C1_CAPTS]) begin
            cap_rise = ext_rise;
            cap_fall = ext_fall;
        end else begin
            cap_rise = state_ff.sync_cap[1] && !state_ff.cap_prev;
            cap_fall = !state_ff.sync_cap[1] && state_ff.cap_prev;
        end
    end
    // capture edge choice
    always_comb begin
        unique case (pin_fn)
            2'b00: cap_hit = cap_rise;
            2'b01: cap_hit = cap_fall;
            2'b10: cap_hit = cap_rise || cap_fall;
            2'b11: cap_hit = 1'b0;
        endcase
    end

    // ****************************************
    // counter tick source
    // ****************************************
    always_comb begin
        unique case (ck_sel)
            ptm_pkg::PTM_CK_SYS4: presc_last = ptm_pkg::DIV4_LAST;
            ptm_pkg::PTM_CK_H16: presc_last = ptm_pkg::DIV16_LAST;
            ptm_pkg::PTM_CK_H64: presc_last = ptm_pkg::DIV64_LAST;
            default: presc_last = ptm_pkg::SUB_LAST;
        endcase
    end
    // pick the tick
    always_comb begin
        unique case (ck_sel)
            ptm_pkg::PTM_CK_SYS: tick = 1'b1;
            ptm_pkg::PTM_CK_SYS4, ptm_pkg::PTM_CK_H16, ptm_pkg::PTM_CK_H64: tick = state_ff.presc == presc_last;
            ptm_pkg::PTM_CK_SUB0, ptm_pkg::PTM_CK_SUB1:
                tick = state_ff.presc == presc_last && state_ff.sub_presc == ptm_pkg::SUB_LAST_HI;
            ptm_pkg::PTM_CK_EXT_RISE: tick = ext_rise;
            ptm_pkg::PTM_CK_EXT_FALL: tick = ext_fall;
        endcase
    end

    // comparators on all sixteen bits
    assign match_a = state_ff.count == state_ff.cmp_a;
    assign match_p = state_ff.count == state_ff.cmp_p;
    // runs only while on and not paused
    assign cnt_en = on_bit && !state_ff.ctrl0[ptm_pkg::C0_PAU];

    // pwm active while below duty, duty over period gives full on
    assign pwm_act = state_ff.count < state_ff.cmp_a;

    // ****************************************
    // output pin: level, then polarity
    // ****************************************
    always_comb begin
        unique case (mode)
            ptm_pkg::PTM_MODE_PWM: begin
                // pwm function select; active level per output_level_ctrl
                unique case (pin_fn)
                    2'b00: lvl_cmp = !state_ff.ctrl1[ptm_pkg::C1_OC];
                    2'b01: lvl_cmp = state_ff.ctrl1[ptm_pkg::C1_OC];
                    2'b10: lvl_cmp = pwm_act ? state_ff.ctrl1[ptm_pkg::C1_OC] : !state_ff.ctrl1[ptm_pkg::C1_OC];
                    2'b11: lvl_cmp = state_ff.pin_lvl;
                endcase
            end
            // timer mode leaves the pin at low, control bits ignored
            ptm_pkg::PTM_MODE_TMR: lvl_cmp = 1'b0;
            default: lvl_cmp = state_ff.pin_lvl;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        cleared = 1'b0;
        new_ctrl0 = state_ff.ctrl0;
        on_rise = 1'b0;
        flag_set = '0;
        // two-stage synchronisers, edge history from stage two
        nxt_state.sync_ck = {state_ff.sync_ck[0], ext_clock_pin};
        nxt_state.ck_prev = state_ff.sync_ck[1];
        nxt_state.sync_cap = {state_ff.sync_cap[0], capture_input_pin};
        nxt_state.cap_prev = state_ff.sync_cap[1];
        // free prescaler
        if (state_ff.presc == presc_last) begin
            nxt_state.presc = '0;
            nxt_state.sub_presc = state_ff.sub_presc + 10'h001;
        end else begin
            nxt_state.presc = state_ff.presc + 6'h01;
        end

        // counting, clearing and matches
        if (cnt_en && tick) begin
            // flag a on match unless compare a is zero outside capture; flag p on match unless clearing on a
            if (match_a && !(mode != ptm_pkg::PTM_MODE_CAP && state_ff.cmp_a == ptm_pkg::WORD_RST)) begin
                flag_set[ptm_pkg::FLAG_A] = 1'b1;
            end
            if (match_p && !((mode == ptm_pkg::PTM_MODE_CMP || mode == ptm_pkg::PTM_MODE_TMR)
                    && state_ff.ctrl1[ptm_pkg::C1_CCLR])) begin
                flag_set[ptm_pkg::FLAG_P] = 1'b1;
            end
            unique case (mode)
                ptm_pkg::PTM_MODE_CMP, ptm_pkg::PTM_MODE_TMR: begin
                    // clear source choice
                    if (state_ff.ctrl1[ptm_pkg::C1_CCLR]) begin
                        cleared = match_a;
                    end else begin
                        // overflow wrap only counts when p is zero
                        cleared = (match_p && state_ff.cmp_p != ptm_pkg::WORD_RST)
                            || (state_ff.count == ptm_pkg::CNT_MAX && state_ff.cmp_p == ptm_pkg::WORD_RST);
                    end
                    if (match_a && mode == ptm_pkg::PTM_MODE_CMP) begin
                        // compare pin action; equal to current level keeps it
                        unique case (pin_fn)
                            2'b00: nxt_state.pin_lvl = state_ff.pin_lvl;
                            2'b01: nxt_state.pin_lvl = 1'b0;
                            2'b10: nxt_state.pin_lvl = 1'b1;
                            2'b11: nxt_state.pin_lvl = !state_ff.pin_lvl;
                        endcase
                    end
                end
                // other modes ignore clear select, clear on p, except pwm single pulse which never clears
                ptm_pkg::PTM_MODE_PWM: begin
                    cleared = match_p && state_ff.cmp_p != ptm_pkg::WORD_RST && pin_fn != 2'b11;
                    if (pin_fn == 2'b11 && match_a) begin
                        // single pulse trailing edge turns itself off
                        nxt_state.pin_lvl = !state_ff.ctrl1[ptm_pkg::C1_OC];
                        new_ctrl0[ptm_pkg::C0_ON] = 1'b0;
                    end
                end
                ptm_pkg::PTM_MODE_CAP: begin
                    cleared = match_p && state_ff.cmp_p != ptm_pkg::WORD_RST;
                end
            endcase
            nxt_state.count = cleared ? ptm_pkg::WORD_RST : state_ff.count + 16'h0001;
        end
        // capture latches count into compare a
        if (mode == ptm_pkg::PTM_MODE_CAP && on_bit && cap_hit) begin
            nxt_state.cmp_a = state_ff.count;
            flag_set[ptm_pkg::FLAG_A] = 1'b1;
        end
        // single pulse: clock pin edge switches the counter on
        if (mode == ptm_pkg::PTM_MODE_PWM && pin_fn == 2'b11 && !on_bit && ext_rise) begin
            new_ctrl0[ptm_pkg::C0_ON] = 1'b1;
        end

        // ---- axi write channel ----
        if (s_axi_awvalid && !state_ff.aw_got) begin
            nxt_state.aw_got = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_ff.w_got) begin
            nxt_state.w_got = 1'b1;
            nxt_state.w_data = s_axi_wdata;
            nxt_state.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = wr_ok ? ptm_pkg::RESP_OKAY : ptm_pkg::RESP_SLVERR;
            if (wr_ok && state_ff.w_strb[0]) begin
                unique case (state_ff.aw_addr)
                    // low bits unimplemented
                    ptm_pkg::ADDR_CTRL0: new_ctrl0 = wbyte & ptm_pkg::C0_WMASK;
                    ptm_pkg::ADDR_CTRL1: nxt_state.ctrl1 = wbyte;
                    ptm_pkg::ADDR_CMPAL: nxt_state.cmp_a[7:0] = wbyte;
                    ptm_pkg::ADDR_CMPAH: nxt_state.cmp_a[15:8] = wbyte;
                    ptm_pkg::ADDR_CMPPL: nxt_state.cmp_p[7:0] = wbyte;
                    ptm_pkg::ADDR_CMPPH: nxt_state.cmp_p[15:8] = wbyte;
                    // write one clears; a same-cycle set wins
                    ptm_pkg::ADDR_FLAGS: nxt_state.flags = state_ff.flags & ~wbyte[1:0];
                    default: ;
                endcase
            end
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end

        // counter_on edge: clear and restore initial level
        on_rise = !on_bit && new_ctrl0[ptm_pkg::C0_ON];
        if (on_rise) begin
            nxt_state.count = ptm_pkg::WORD_RST;
            if (mode == ptm_pkg::PTM_MODE_CMP) begin
                nxt_state.pin_lvl = state_ff.ctrl1[ptm_pkg::C1_OC];
            end else if (mode == ptm_pkg::PTM_MODE_PWM) begin
                // single pulse leading edge is the active level
                nxt_state.pin_lvl = pin_fn == 2'b11 ? state_ff.ctrl1[ptm_pkg::C1_OC]
                    : !state_ff.ctrl1[ptm_pkg::C1_OC];
            end
        end else if (mode == ptm_pkg::PTM_MODE_PWM && pin_fn == 2'b11 && on_bit && !new_ctrl0[ptm_pkg::C0_ON]) begin
            // software turned off during the pulse: trailing edge
            nxt_state.pin_lvl = !state_ff.ctrl1[ptm_pkg::C1_OC];
        end
        nxt_state.ctrl0 = new_ctrl0;
        // match events land after any clear, so they win
        nxt_state.flags = nxt_state.flags | flag_set;

        // ---- axi read channel ----
        if (s_axi_arvalid && !state_ff.rvalid) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = ptm_pkg::RESP_OKAY;
            nxt_state.rdata = '0;
            unique case (s_axi_araddr)
                ptm_pkg::ADDR_CTRL0: nxt_state.rdata[7:0] = state_ff.ctrl0;
                ptm_pkg::ADDR_CTRL1: nxt_state.rdata[7:0] = state_ff.ctrl1;
                ptm_pkg::ADDR_CNTL: nxt_state.rdata[7:0] = state_ff.count[7:0];
                ptm_pkg::ADDR_CNTH: nxt_state.rdata[7:0] = state_ff.count[15:8];
                ptm_pkg::ADDR_CMPAL: nxt_state.rdata[7:0] = state_ff.cmp_a[7:0];
                ptm_pkg::ADDR_CMPAH: nxt_state.rdata[7:0] = state_ff.cmp_a[15:8];
                ptm_pkg::ADDR_CMPPL: nxt_state.rdata[7:0] = state_ff.cmp_p[7:0];
                ptm_pkg::ADDR_CMPPH: nxt_state.rdata[7:0] = state_ff.cmp_p[15:8];
                ptm_pkg::ADDR_FLAGS: nxt_state.rdata[1:0] = state_ff.flags;
                default: nxt_state.rresp = ptm_pkg::RESP_SLVERR;
            endcase
        end else if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end

        // polarity last
        nxt_state.timer_out = lvl_cmp ^ (state_ff.ctrl1[ptm_pkg::C1_POL] && mode != ptm_pkg::PTM_MODE_TMR);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = !state_ff.aw_got;
    assign s_axi_wready = !state_ff.w_got;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_arready = !state_ff.rvalid;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign timer_output_pin = state_ff.timer_out;
    assign match_flags = state_ff.flags;

    // ****************************************
    // checks
    // ****************************************
    a_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff.ctrl0[ptm_pkg::C0_PAU] && on_bit && !on_rise |=> state_ff.count == $past(state_ff.count))
        else $error("count moved while paused");
    a_on_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        on_rise |=> state_ff.count == ptm_pkg::WORD_RST)
        else $error("count not cleared on enable");
    a_off_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !on_bit && !on_rise |=> $stable(state_ff.count))
        else $error("count moved while off");
    a_cmp_init: assert property (@(posedge aclk) disable iff (!aresetn)
        on_rise && mode == ptm_pkg::PTM_MODE_CMP |=> state_ff.pin_lvl == $past(state_ff.ctrl1[ptm_pkg::C1_OC]))
        else $error("initial level not restored");
    a_pol_out: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == ptm_pkg::PTM_MODE_CMP && $stable(mode) && $stable(state_ff.ctrl1)
        |=> timer_output_pin == ($past(state_ff.pin_lvl) ^ $past(state_ff.ctrl1[ptm_pkg::C1_POL])))
        else $error("polarity wrong");
    a_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_en && tick && match_a && state_ff.cmp_a != ptm_pkg::WORD_RST |=> state_ff.flags[ptm_pkg::FLAG_A])
        else $error("flag a missed");
    a_compare_a_value_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == ptm_pkg::PTM_MODE_CMP && state_ff.ctrl1[ptm_pkg::C1_CCLR] && cnt_en && tick && match_a && !on_rise
        |=> state_ff.count == ptm_pkg::WORD_RST)
        else $error("no clear on a match");
    a_ovf_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_en && tick && !on_rise && state_ff.count == ptm_pkg::CNT_MAX && state_ff.cmp_p == ptm_pkg::WORD_RST
        && mode == ptm_pkg::PTM_MODE_CMP && !state_ff.ctrl1[ptm_pkg::C1_CCLR] |=> state_ff.count == ptm_pkg::WORD_RST)
        else $error("no overflow clear with p zero");
    a_rsv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff.ctrl0[2:0] == 3'h0)
        else $error("reserved bits set");
endmodule

//--- tb/tb_ptm_periodic_timer.sv
`timescale 1ns/10ps
module tb_ptm_periodic_timer;
    // ****************************************
    // bench signals
    // ****************************************
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin, cap_pin;
    logic awready, wready, bvalid, arready, rvalid, pin;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_r, wr_r, flags;
    int fail_count, cmp_count, n;
    localparam logic [5:0] C0 = ptm_pkg::ADDR_CTRL0;
    localparam logic [5:0] C1 = ptm_pkg::ADDR_CTRL1;
    localparam logic [5:0] FL = ptm_pkg::ADDR_FLAGS;
    // per case: pin action, initial level, invert, level after match
    logic [1:0] io [5] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h0};
    logic oc [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic pl [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic ex [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    ptm_periodic_timer u_ptm_periodic_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_clock_pin(ext_pin), .capture_input_pin(cap_pin), .timer_output_pin(pin), .match_flags(flags));
    // 100 mhz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // a used-up bound counts as a mismatch
    task guard;
        if (n >= 300) begin
            fail_count++;
            end_of_test;
        end
    endtask
    // write: both halves offered together, each dropped once taken
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 300);
        wr_r = bresp;
        bready <= 1'b0;
        guard;
    endtask
    // read: data and response taken at the edge that shows rvalid
    task rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 300);
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'b0;
        guard;
    endtask
    task wait_pin(input logic e);
        n = 0;
        while (pin !== e && n < 300) begin
            @(posedge aclk);
            n++;
        end
        guard;
        chk({31'h0, pin}, {31'h0, e});
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin, cap_pin} = 8'h00;
        {awaddr, araddr, wdata, wstrb} = 48'h0000000000001;
        fail_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // the eight words from control 0 to compare p high read zero after reset
        for (int i = 0; i < 8; i++) begin
            rd(6'(i * 4));
            chk(rd_v, 32'h0);
        end
        rd(ptm_pkg::ADDR_TOP);
        chk({30'h0, rd_r}, {30'h0, ptm_pkg::RESP_SLVERR});
        wr(ptm_pkg::ADDR_TOP, 8'h01);
        chk({30'h0, wr_r}, {30'h0, ptm_pkg::RESP_SLVERR});
        rd(C1);
        chk(rd_v, 32'h0);
        wr(C0, 8'h07);
        rd(C0);
        chk(rd_v, 32'h0);
        $display("test registers done");
        // compare a at 0x20, each pin action from a paused start
        wr(ptm_pkg::ADDR_CMPAL, 8'h20);
        for (int k = 0; k < 5; k++) begin
            wr(C0, 8'h90);
            wr(C1, {2'b00, io[k], oc[k], pl[k], 2'b00});
            wr(C0, 8'h98);
            rd(ptm_pkg::ADDR_CNTL);
            chk(rd_v, 32'h0);
            wait_pin(oc[k] ^ pl[k]);
            wr(C0, 8'h18);
            wait_pin(ex[k]);
        end
        // stop keeps the count, flags sticky until cleared
        wr(C0, 8'h10);
        rd(ptm_pkg::ADDR_CNTL);
        wdata <= rd_v;
        rd(ptm_pkg::ADDR_CNTL);
        chk(rd_v, wdata);
        chk({31'h0, flags[ptm_pkg::FLAG_A]}, 32'h1);
        wr(FL, 8'h01);
        rd(FL);
        chk({31'h0, rd_v[ptm_pkg::FLAG_A]}, 32'h0);
        $display("test compare output done");
        // clear on compare a keeps the count at or below 0x20
        wr(C1, 8'h01);
        wr(C0, 8'h18);
        repeat (300) @(posedge aclk);
        rd(ptm_pkg::ADDR_CNTH);
        chk(rd_v, 32'h0);
        rd(ptm_pkg::ADDR_CNTL);
        chk({31'h0, rd_v <= 32'h20}, 32'h1);
        $display("test clear select done");
        // capture pin rise, capture disabled, clock pin rise as capture source
        for (int j = 0; j < 3; j++) begin
            cap_pin <= 1'b0;
            ext_pin <= 1'b0;
            wr(C0, 8'h10);
            wr(FL, 8'h03);
            wr(ptm_pkg::ADDR_CMPAL, 8'h20);
            wr(C1, j == 1 ? 8'h70 : (j == 2 ? 8'h42 : 8'h40));
            wr(C0, 8'h18);
            if (j == 2) ext_pin <= 1'b1;
            else cap_pin <= 1'b1;
            repeat (8) @(posedge aclk);
            chk({31'h0, flags[ptm_pkg::FLAG_A]}, {31'h0, j != 1});
        end
        $display("test capture done");
        end_of_test;
    end
endmodule
